// file: design/rmc_resolver_mode_config.v
// Mode configuration of a resolver-to-digital converter: strap capture,
// serial setting register, parallel output select and excitation phase checks.
// Assumes serial pins come from another domain; CORE_CLK at 50 MHz samples them.
//
// Notes on behaviour
// - After power-on, strap pins are read as inputs briefly and latched.
// - Strap excitation bit zero selects current mode, signal leads by 90 within 45.
// - Strap excitation bit one selects voltage mode, zero phase within 45.
// - Serial writes never change the strapped excitation type.
// - Written setting holds until another valid write.
// - Reboot command or power loss restores the strapped defaults.
// - Setting bit 0 picks angle word or encoder pulses on data pins.
// - External excitation input is the demodulation phase reference.
// - Phase offsets under 45 degrees are corrected automatically.
// - Beyond 45 degrees loop gain falls; settling may be slow.
// - Host changes data on rising clock; device captures on falling edge.
// - More than twelve clocks in a frame: last twelve bits kept.
// - Fewer than twelve clocks in a frame: frame discarded.
`timescale 1ns/1ns
`include "rmc_defs.vh"

module rmc_resolver_mode_config
(
  // Clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // Serial setting port
  input wire SETTING_SELECT_N,
  input wire SETTING_CLK,
  input wire SETTING_SERIAL_IN,
  // Strap pins, shared with parallel data pins
  input wire [11:0] STRAP_IN,
  output reg [11:0] STRAP_SAMPLE_N,
  // Excitation
  input wire EXCITATION_DIRECTION_N,
  output wire EXCITATION_PIN_OE,
  input wire EXCITATION_REF,
  input wire [7:0] PHASE_OFFSET_DEG,
  // Converter sources
  input wire [11:0] ANGLE_WORD,
  input wire [5:0] ENCODER_PULSES,
  // Results
  output reg [11:0] PARALLEL_DATA_PINS,
  output reg [11:0] SERIAL_MODE_SETTING,
  output reg EXCITATION_TYPE_STRAP,
  output reg [7:0] EXPECTED_LEAD_DEG,
  output reg DEMOD_REF,
  output reg PHASE_CORRECT_EN,
  output reg LOOP_GAIN_REDUCED,
  output reg STRAP_DONE
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
wire sel_s2;
wire clk_s2;
wire din_s2;
wire ref_s2;
wire dir_s2;
wire [11:0] strap_s2;
reg clk_prev;
reg sel_prev;

// Select idles high, so it resets to its idle level
rmc_sync2
#(
  .WIDTH(1),
  .INIT(1'b1)
)
i_sel_sync
(
  .clk(CORE_CLK),
  .rst_n(RST_N),
  .d(SETTING_SELECT_N),
  .q(sel_s2)
);

rmc_sync2
#(
  .WIDTH(1),
  .INIT(1'b0)
)
i_clk_sync
(
  .clk(CORE_CLK),
  .rst_n(RST_N),
  .d(SETTING_CLK),
  .q(clk_s2)
);

rmc_sync2
#(
  .WIDTH(1),
  .INIT(1'b0)
)
i_din_sync
(
  .clk(CORE_CLK),
  .rst_n(RST_N),
  .d(SETTING_SERIAL_IN),
  .q(din_s2)
);

rmc_sync2
#(
  .WIDTH(1),
  .INIT(1'b0)
)
i_ref_sync
(
  .clk(CORE_CLK),
  .rst_n(RST_N),
  .d(EXCITATION_REF),
  .q(ref_s2)
);

rmc_sync2
#(
  .WIDTH(1),
  .INIT(1'b1)
)
i_dir_sync
(
  .clk(CORE_CLK),
  .rst_n(RST_N),
  .d(EXCITATION_DIRECTION_N),
  .q(dir_s2)
);

rmc_sync2
#(
  .WIDTH(12),
  .INIT(12'h000)
)
i_strap_sync
(
  .clk(CORE_CLK),
  .rst_n(RST_N),
  .d(STRAP_IN),
  .q(strap_s2)
);

// Edge detectors reset to the idle pin levels
always @(posedge CORE_CLK)
begin
  if (!RST_N)
  begin
    clk_prev <= 1'b0;
    sel_prev <= 1'b1;
  end
  else
  begin
    clk_prev <= clk_s2;
    sel_prev <= sel_s2;
  end
end

wire clk_fall = clk_prev & ~clk_s2;
wire sel_active = ~sel_s2;
wire sel_rise = ~sel_prev & sel_s2;

////////////////////////////////////////////////////////////////////////////////
// Strap capture window
reg [7:0] strap_cnt;
reg [11:0] strap_value;
reg reboot_req;
reg strap_done_d;

always @(posedge CORE_CLK)
begin
  if (!RST_N)
  begin
    strap_cnt <= 8'h00;
    STRAP_DONE <= 1'b0;
    STRAP_SAMPLE_N <= 12'h000;
    strap_value <= 12'h000;
    EXCITATION_TYPE_STRAP <= 1'b0;
  end
  else if (reboot_req)
  begin
    strap_cnt <= 8'h00;
    STRAP_DONE <= 1'b0;
    STRAP_SAMPLE_N <= 12'h000;
  end
  else if (!STRAP_DONE)
  begin
    // Data pins float as inputs while straps settle
    STRAP_SAMPLE_N <= 12'h000;
    if (strap_cnt == `RMC_STRAP_CYCLES)
    begin
      strap_value <= strap_s2;
      EXCITATION_TYPE_STRAP <= strap_s2[`RMC_FRAME_BITS-1];
      STRAP_DONE <= 1'b1;
      STRAP_SAMPLE_N <= 12'hFFF;
    end
    else
    begin
      strap_cnt <= strap_cnt + 8'h01;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Serial setting frame
reg [11:0] shift;
reg [3:0] bit_cnt;

always @(posedge CORE_CLK)
begin
  if (!RST_N)
  begin
    shift <= 12'h000;
    bit_cnt <= 4'h0;
  end
  else if (sel_active & clk_fall)
  begin
    shift <= {shift[10:0], din_s2};
    if (bit_cnt != 4'hC)
    begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end
  else if (sel_rise | ~sel_active)
  begin
    bit_cnt <= 4'h0;
  end
end

// First bit shifted in is register bit 0
wire [11:0] frame = {shift[0], shift[1], shift[2], shift[3], shift[4], shift[5],
  shift[6], shift[7], shift[8], shift[9], shift[10], shift[11]};
wire frame_ok = sel_rise & (bit_cnt == 4'hC);
wire frame_reboot = frame[9:6] == `RMC_SPECIAL_REBOOT;

always @(posedge CORE_CLK)
begin
  if (!RST_N)
  begin
    SERIAL_MODE_SETTING <= 12'h000;
    reboot_req <= 1'b0;
    strap_done_d <= 1'b0;
  end
  else
  begin
    reboot_req <= frame_ok & frame_reboot & STRAP_DONE;
    strap_done_d <= STRAP_DONE;
    // Lags capture by one cycle so the fresh strap copy is loaded
    if (!strap_done_d)
    begin
      SERIAL_MODE_SETTING <= strap_value;
    end
    else if (frame_ok & !frame_reboot)
    begin
      SERIAL_MODE_SETTING <= frame;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Parallel outputs and excitation
always @(posedge CORE_CLK)
begin
  if (!RST_N)
  begin
    PARALLEL_DATA_PINS <= 12'h000;
    EXPECTED_LEAD_DEG <= 8'h00;
    DEMOD_REF <= 1'b0;
    PHASE_CORRECT_EN <= 1'b0;
    LOOP_GAIN_REDUCED <= 1'b0;
  end
  else
  begin
    if (SERIAL_MODE_SETTING[`RMC_BIT_OUT_MODE])
    begin
      PARALLEL_DATA_PINS <= {6'h00, ENCODER_PULSES};
    end
    else
    begin
      PARALLEL_DATA_PINS <= ANGLE_WORD;
    end
    if (EXCITATION_TYPE_STRAP)
    begin
      EXPECTED_LEAD_DEG <= 8'h00;
    end
    else
    begin
      EXPECTED_LEAD_DEG <= `RMC_CURRENT_LEAD_DEG;
    end
    DEMOD_REF <= ref_s2;
    PHASE_CORRECT_EN <= PHASE_OFFSET_DEG < `RMC_PHASE_LIMIT_DEG;
    LOOP_GAIN_REDUCED <= PHASE_OFFSET_DEG > `RMC_PHASE_LIMIT_DEG;
  end
end

// Excitation pins drive only when direction is high
assign EXCITATION_PIN_OE = dir_s2;

endmodule

////////////////////////////////////////////////////////////////////////////////
// Two flip-flop synchroniser for pins from other domains
module rmc_sync2
#(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;

always @(posedge clk)
begin
  if (!rst_n)
  begin
    stage1 <= INIT;
    stage2 <= INIT;
  end
  else
  begin
    stage1 <= d;
    stage2 <= stage1;
  end
end

assign q = stage2;

endmodule

// file: design/rmc_defs.vh
// Constants for the resolver mode configuration block.
// Assumes inclusion by bare name from the design file.
`ifndef RMC_DEFS_VH
`define RMC_DEFS_VH
`define RMC_FRAME_BITS 12
`define RMC_CNT_W 4
`define RMC_BIT_OUT_MODE 0
`define RMC_BIT_SPECIAL_LSB 6
`define RMC_SPECIAL_REBOOT 4'hD
`define RMC_STRAP_CYCLES 8'h20
`define RMC_PHASE_LIMIT_DEG 8'h2D
`define RMC_CURRENT_LEAD_DEG 8'h5A
`endif

// file: dv/rmc_host_model.sv
// Host model that sends serial setting frames, 160 ns per bit.
// Assumes the core clock paces the serial clock edges.
`timescale 1ns/1ns
module rmc_host_model
(
  input wire CORE_CLK,
  output logic SETTING_SELECT_N = 1'b1,
  output logic SETTING_CLK = 1'b0,
  output logic SETTING_SERIAL_IN = 1'b0
);
  task send(input logic [15:0] v, input int n);
    int i;
    @(posedge CORE_CLK);
    SETTING_SELECT_N <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      repeat (4) @(posedge CORE_CLK);
      SETTING_CLK <= 1'b1;
      SETTING_SERIAL_IN <= v[i];
      repeat (4) @(posedge CORE_CLK);
      SETTING_CLK <= 1'b0;
    end
    repeat (4) @(posedge CORE_CLK);
    SETTING_SELECT_N <= 1'b1;
    SETTING_SERIAL_IN <= ~SETTING_SERIAL_IN;
    repeat (4) @(posedge CORE_CLK);
  endtask
endmodule

// file: dv/rmc_monitor.sv
// Checker bound to the mode configuration block.
// Assumes slow inputs hold each level for several core cycles.
`timescale 1ns/1ns
module rmc_monitor
(
  input logic CORE_CLK, RST_N, SETTING_SELECT_N, EXCITATION_DIRECTION_N, EXCITATION_PIN_OE,
  input logic EXCITATION_REF, DEMOD_REF, PHASE_CORRECT_EN, LOOP_GAIN_REDUCED, STRAP_DONE,
  input logic EXCITATION_TYPE_STRAP,
  input logic [7:0] PHASE_OFFSET_DEG, EXPECTED_LEAD_DEG,
  input logic [5:0] ENCODER_PULSES,
  input logic [11:0] ANGLE_WORD, PARALLEL_DATA_PINS, SERIAL_MODE_SETTING
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_set;
    STRAP_DONE && $past(STRAP_DONE);
  endsequence
  sequence s_quiet;
    (SETTING_SELECT_N && STRAP_DONE) [*8];
  endsequence
  a_lead_mode: assert property (s_set |->
    EXPECTED_LEAD_DEG == (EXCITATION_TYPE_STRAP ? 8'h00 : 8'h5A)) else $error("lead");
  a_type_fixed: assert property (s_set |-> $stable(EXCITATION_TYPE_STRAP))
    else $error("type");
  a_setting_hold: assert property (s_quiet |-> $stable(SERIAL_MODE_SETTING))
    else $error("hold");
  a_pin_select: assert property (s_set |=> PARALLEL_DATA_PINS ==
    ($past(SERIAL_MODE_SETTING[0]) ? {6'h00, $past(ENCODER_PULSES)} : $past(ANGLE_WORD)))
    else $error("pins");
  a_dir_follow: assert property ($stable(EXCITATION_DIRECTION_N) [*4] |->
    EXCITATION_PIN_OE == EXCITATION_DIRECTION_N) else $error("dir");
  a_ref_track: assert property (EXCITATION_REF [*4] |-> DEMOD_REF)
    else $error("ref");
  a_phase_fix: assert property (1 |=>
    PHASE_CORRECT_EN == ($past(PHASE_OFFSET_DEG) < 8'h2D)) else $error("fix");
  a_gain_drop: assert property (1 |=>
    LOOP_GAIN_REDUCED == ($past(PHASE_OFFSET_DEG) > 8'h2D)) else $error("gain");
endmodule
bind rmc_resolver_mode_config rmc_monitor i_mon (.*);

// file: dv/resolver_mode_config_test.sv
// Bench for the mode configuration block.
// Assumes the host model drives all serial frames.
`timescale 1ns/1ns
module resolver_mode_config_test;
  logic CORE_CLK = 1'b0, RST_N = 1'b0, EXCITATION_DIRECTION_N = 1'b1, EXCITATION_REF = 1'b0;
  logic [7:0] PHASE_OFFSET_DEG = 8'h00;
  logic [5:0] ENCODER_PULSES = 6'h00;
  logic [11:0] ANGLE_WORD = 12'h000, STRAP_IN = 12'h0A5;
  wire SETTING_SELECT_N, SETTING_CLK, SETTING_SERIAL_IN, EXCITATION_PIN_OE, DEMOD_REF;
  wire PHASE_CORRECT_EN, LOOP_GAIN_REDUCED, EXCITATION_TYPE_STRAP, STRAP_DONE;
  wire [7:0] EXPECTED_LEAD_DEG;
  wire [11:0] STRAP_SAMPLE_N, PARALLEL_DATA_PINS, SERIAL_MODE_SETTING;
  logic [31:0] r;
  logic [15:0] d;
  int seed = 32'h7C8FC882, n_mismatch = 0, check_count = 0;
  always #10 CORE_CLK = ~CORE_CLK;
  rmc_host_model i_host (.*);
  rmc_resolver_mode_config i_dut (.*);
  always @(posedge CORE_CLK)
  begin
    r = $random(seed);
    {ANGLE_WORD, ENCODER_PULSES, PHASE_OFFSET_DEG} <= r[25:0];
    if (r[31:28] == 4'h0) EXCITATION_REF <= ~EXCITATION_REF;
    if (r[31:26] == 6'h3F) EXCITATION_DIRECTION_N <= ~EXCITATION_DIRECTION_N;
  end
  function logic [11:0] kept(input logic [15:0] v, input int n);
    return 12'(v >> (n - 12));
  endfunction
  task chk(input string s, input logic [11:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task settle(input logic v);
    int k;
    for (k = 0; k < 300 && STRAP_DONE !== v; k++)
      @(negedge CORE_CLK);
    repeat (2) @(negedge CORE_CLK);
    chk("done", {11'h0, STRAP_DONE}, {11'h0, v});
    chk("sample", STRAP_SAMPLE_N, v ? 12'hFFF : 12'h000);
  endtask
  task straps;
    settle(1'b1);
    chk("default", SERIAL_MODE_SETTING, STRAP_IN);
    chk("type", {11'h0, EXCITATION_TYPE_STRAP}, {11'h0, STRAP_IN[11]});
    chk("lead", {4'h0, EXPECTED_LEAD_DEG}, STRAP_IN[11] ? 12'h000 : 12'h05A);
  endtask
  task frame(input logic [15:0] v, input int n, input logic [11:0] e);
    i_host.send(v, n);
    repeat (8) @(negedge CORE_CLK);
    chk("setting", SERIAL_MODE_SETTING, e);
    chk("type", {11'h0, EXCITATION_TYPE_STRAP}, {11'h0, STRAP_IN[11]});
  endtask
  task stop_test;
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    straps();
    d = 16'($random(seed)) & 16'hFDFF;
    frame(d, 12, kept(d, 12));
    frame(~d, 11, kept(d, 12));
    d = 16'($random(seed)) & 16'hF7FF;
    frame(d, 14, kept(d, 14));
    @(posedge CORE_CLK);
    STRAP_IN <= ~STRAP_IN;
    i_host.send(16'h0340, 12);
    settle(1'b0);
    straps();
    stop_test();
  end
  initial
  begin
    repeat (5000) @(posedge CORE_CLK);
    n_mismatch++;
    stop_test();
  end
endmodule
